// ===== frtc_capture_chan.sv
`timescale 1ns/10ps
// One input capture channel
module frtc_capture_chan (
   input wire logic clk,
   input wire logic rst_n,
   frtc_chan_if.chan ch
);
   import frtc_pkg::*;
   logic pin_prev; // Last synchronised level
   logic active_edge; // Selected transition seen
   logic blocked; // High byte read, low not yet
   logic clear_armed; // Status read saw flag set
   logic fire; // Capture this cycle

   // Edge detect on the already synchronised level
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) pin_prev <= 1'b0;
      else pin_prev <= ch.pin_level;
   end

   assign active_edge = ch.edge_rise ? (ch.pin_level & ~pin_prev)
                                     : (~ch.pin_level & pin_prev);
   assign fire = active_edge & ch.enable & ~blocked;

   // High read freezes the channel until the low byte is read or written
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) blocked <= 1'b0;
      else if (ch.high_read) blocked <= 1'b1;
      else if (ch.low_access) blocked <= 1'b0;
   end

   // Latest event overwrites while the channel is enabled and not blocked
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) ch.value <= FRTC_CAP_RESET;
      else if (fire) ch.value <= ch.count;
   end

   // First clearing step remembered until a low access
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) clear_armed <= 1'b0;
      else if (ch.low_access) clear_armed <= 1'b0;
      else if (ch.status_read && ch.flag) clear_armed <= 1'b1;
   end

   // Set wins over a clear in the same cycle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) ch.flag <= 1'b0;
      else if (fire) ch.flag <= 1'b1;
      else if (ch.low_access && clear_armed) ch.flag <= 1'b0;
   end
endmodule : frtc_capture_chan

// ===== frtc_chan_if.sv
`timescale 1ns/10ps
// Links the top with one capture channel
interface frtc_chan_if;
   logic pin_level; // Synchronised capture pin
   logic edge_rise; // 1 = rising edge active
   logic enable; // Channel may capture
   logic [15:0] count; // Live counter value
   logic status_read; // Status register read pulse
   logic high_read; // Capture high byte read pulse
   logic low_access; // Capture low byte read or write pulse
   logic flag; // Capture flag
   logic [15:0] value; // Captured counter value
   modport owner (output pin_level, edge_rise, enable, count, status_read, high_read,
      low_access, input flag, value);
   modport chan (input pin_level, edge_rise, enable, count, status_read, high_read,
      low_access, output flag, value);
endinterface : frtc_chan_if

// ===== frtc_chk.sv
`timescale 1ns/10ps
// Port-level checks for the free-running timer
module frtc_chk
   import frtc_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic cpu_irq_mask,
   input wire logic halt_mode,
   input wire logic timer_irq,
   input wire logic [15:0] counter_value,
   input wire logic one_pulse_active
);
   logic [7:0] c1; // Shadow of control one
   logic [7:0] c2; // Shadow of control two
   logic [15:0] cnt_q; // Counter one cycle back
   logic [7:0] snap; // Expected frozen low byte
   logic seq_open; // High byte read, low not yet
   logic [1:0] sel; // Clock select shadow
   assign sel = c2[1:0];
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // Control shadows follow bus traffic only; cnt_q and snap sample the counter
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         c1 <= 8'h00;
         c2 <= 8'h00;
         cnt_q <= FRTC_CNT_RELOAD;
         snap <= 8'h00;
         seq_open <= 1'b0;
      end else begin
         cnt_q <= counter_value;
         if (reg_wr && reg_addr == FRTC_OFS_CTRL_ONE) c1 <= reg_wdata & FRTC_C1_MASK;
         if (reg_wr && reg_addr == FRTC_OFS_CTRL_TWO) c2 <= reg_wdata & FRTC_C2_MASK;
         // Repeated high reads keep the first snapshot
         if (reg_rd && reg_addr == FRTC_OFS_CNT_HI && !seq_open) begin
            snap <= counter_value[7:0];
            seq_open <= 1'b1;
         end else if (reg_rd && reg_addr == FRTC_OFS_CNT_LO) begin
            seq_open <= 1'b0;
         end
      end
   end
   sequence rollover_s;
      counter_value == 16'hffff ##1 counter_value == 16'h0000;
   endsequence
   sequence low_in_seq_s;
      reg_rd && reg_addr == FRTC_OFS_CNT_LO && seq_open;
   endsequence
   reload_write_a: assert property (
      reg_wr && (reg_addr == FRTC_OFS_CNT_LO || reg_addr == FRTC_OFS_ALT_LO)
      |=> counter_value == FRTC_CNT_RELOAD) else $error("counter not reloaded");
   count_step_a: assert property (
      !$past(reg_wr) |-> 16'(counter_value - cnt_q) <= 16'h0001
      || counter_value == FRTC_CNT_RELOAD) else $error("counter jumped");
   halt_hold_a: assert property (
      halt_mode && !reg_wr |=> $stable(counter_value)) else $error("counted in halt");
   div8_rate_a: assert property (
      sel == FRTC_CLK_DIV8 && $past(sel) == FRTC_CLK_DIV8 && $changed(counter_value)
      && !$past(reg_wr) |=> ($stable(counter_value) || sel != FRTC_CLK_DIV8) [*7])
      else $error("divide by eight too fast");
   ext_rate_a: assert property (
      sel == FRTC_CLK_EXT && $changed(counter_value) && !$past(reg_wr)
      |=> ($stable(counter_value) || sel != FRTC_CLK_EXT) [*3]) else $error("ext rate");
   mask_block_a: assert property (
      cpu_irq_mask |-> !timer_irq) else $error("interrupt while masked");
   irq_cause_a: assert property (
      timer_irq |-> c1[FRTC_C1_OVF_IE] || c1[FRTC_C1_CAP_IE]) else $error("irq no enable");
   rollover_irq_a: assert property (
      rollover_s ##0 (c1[FRTC_C1_OVF_IE] && !cpu_irq_mask) |-> timer_irq)
      else $error("rollover gave no interrupt");
   high_read_a: assert property (
      reg_rd && reg_addr == FRTC_OFS_CNT_HI |=> reg_rdata == cnt_q[15:8])
      else $error("high byte wrong");
   frozen_low_a: assert property (
      low_in_seq_s |=> reg_rdata == snap) else $error("low byte not frozen");
   live_low_a: assert property (
      reg_rd && reg_addr == FRTC_OFS_CNT_LO && !seq_open |=> reg_rdata == cnt_q[7:0])
      else $error("lone low read not live");
   pulse_mode_a: assert property (
      one_pulse_active == (c2[FRTC_C2_ONE_PULSE] || c2[FRTC_C2_PWM]))
      else $error("pulse mode flag wrong");
endmodule : frtc_chk

bind frtc_top frtc_chk u_chk (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .cpu_irq_mask(cpu_irq_mask), .halt_mode(halt_mode), .timer_irq(timer_irq),
   .counter_value(counter_value), .one_pulse_active(one_pulse_active));

// ===== frtc_pins.sv
`timescale 1ns/10ps
// Far side: external clock source and capture signals
module frtc_pins (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ext_go,
   input wire logic [1:0] cap_go,
   output logic ext_clock_pin,
   output logic capture_pin_one,
   output logic capture_pin_two
);
   logic [3:0] ext_cnt; // Phase of the current external pulse
   // One pulse: four cycles high, then low; still between pulses
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ext_cnt <= 4'h0;
      end else if (ext_go) begin
         ext_cnt <= 4'h8;
      end else if (ext_cnt != 4'h0) begin
         ext_cnt <= ext_cnt - 4'h1;
      end
   end
   // Edges kept at least four cpu edges apart
   assign ext_clock_pin = (ext_cnt > 4'h4);
   // Capture pins toggle on request and hold their level
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         capture_pin_one <= 1'b0;
         capture_pin_two <= 1'b0;
      end else begin
         capture_pin_one <= capture_pin_one ^ cap_go[0];
         capture_pin_two <= capture_pin_two ^ cap_go[1];
      end
   end
endmodule : frtc_pins

// ===== frtc_pkg.sv
package frtc_pkg;
   localparam int unsigned FRTC_CNT_W = 16; // Counter width
   localparam int unsigned FRTC_ADDR_W = 4; // Register bus address width
   localparam int unsigned FRTC_DATA_W = 8; // Register bus data width
   localparam logic [15:0] FRTC_CNT_RELOAD = 16'hfffc; // Reset and reload value
   localparam logic [15:0] FRTC_CNT_MAX = 16'hffff; // Value before rollover
   localparam logic [15:0] FRTC_CAP_RESET = 16'h0000; // Capture value after reset
   // Register byte offsets
   localparam logic [3:0] FRTC_OFS_CTRL_ONE = 4'h0;
   localparam logic [3:0] FRTC_OFS_CTRL_TWO = 4'h1;
   localparam logic [3:0] FRTC_OFS_STATUS = 4'h2;
   localparam logic [3:0] FRTC_OFS_CAP1_HI = 4'h3;
   localparam logic [3:0] FRTC_OFS_CAP1_LO = 4'h4;
   localparam logic [3:0] FRTC_OFS_CAP2_HI = 4'h5;
   localparam logic [3:0] FRTC_OFS_CAP2_LO = 4'h6;
   localparam logic [3:0] FRTC_OFS_CNT_HI = 4'h7;
   localparam logic [3:0] FRTC_OFS_CNT_LO = 4'h8;
   localparam logic [3:0] FRTC_OFS_ALT_HI = 4'h9;
   localparam logic [3:0] FRTC_OFS_ALT_LO = 4'ha;
   // Control one fields
   localparam int unsigned FRTC_C1_EDGE1 = 0; // Capture one edge, 1 = rising
   localparam int unsigned FRTC_C1_OVF_IE = 5; // Overflow interrupt enable
   localparam int unsigned FRTC_C1_CAP_IE = 7; // Capture interrupt enable
   localparam logic [7:0] FRTC_C1_MASK = 8'ha1; // Writable bits
   // Control two fields
   localparam int unsigned FRTC_C2_CLK_LO = 0; // Clock select, two bits
   localparam int unsigned FRTC_C2_EXT_EDGE = 2; // External edge, 1 = rising
   localparam int unsigned FRTC_C2_EDGE2 = 3; // Capture two edge, 1 = rising
   localparam int unsigned FRTC_C2_ONE_PULSE = 4; // One pulse select
   localparam int unsigned FRTC_C2_PWM = 5; // Pwm select
   localparam logic [7:0] FRTC_C2_MASK = 8'h3f; // Writable bits
   // Status fields
   localparam int unsigned FRTC_ST_CAP1 = 7;
   localparam int unsigned FRTC_ST_CAP2 = 6;
   localparam int unsigned FRTC_ST_OVF = 5;
   localparam logic [7:0] FRTC_RESET_BYTE = 8'h00; // Control reset value
   // Clock select codes
   localparam logic [1:0] FRTC_CLK_DIV4 = 2'h0;
   localparam logic [1:0] FRTC_CLK_DIV8 = 2'h1;
   localparam logic [1:0] FRTC_CLK_DIV2 = 2'h2;
   localparam logic [1:0] FRTC_CLK_EXT = 2'h3;
   // Prescaler masks, tick when all masked bits are one
   localparam logic [2:0] FRTC_PRE_DIV2 = 3'h1;
   localparam logic [2:0] FRTC_PRE_DIV4 = 3'h3;
   localparam logic [2:0] FRTC_PRE_DIV8 = 3'h7;
endpackage : frtc_pkg

// ===== frtc_top.sv
`timescale 1ns/10ps
// Free-running timer with two input capture channels
module frtc_top #(
   parameter bit REDUCED = 1'b0 // Drops the second capture channel
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [frtc_pkg::FRTC_ADDR_W-1:0] reg_addr,
   input wire logic [frtc_pkg::FRTC_DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [frtc_pkg::FRTC_DATA_W-1:0] reg_rdata,
   input wire logic cpu_irq_mask,
   input wire logic halt_mode,
   input wire logic ext_clock_pin,
   input wire logic capture_pin_one,
   input wire logic capture_pin_two,
   output logic timer_irq,
   output logic [frtc_pkg::FRTC_CNT_W-1:0] counter_value,
   output logic one_pulse_active
);
   import frtc_pkg::*;

   // Control and configuration
   logic [7:0] timer_control_one; // Interrupt enables, edge one
   logic [7:0] timer_control_two; // Clock select, modes, edge two
   logic [1:0] clock_select_field; // Counter clock source
   logic ext_clock_edge_select; // 1 = rising external edge counts
   logic overflow_irq_enable; // Overflow interrupt enable
   logic capture_irq_enable; // Shared capture interrupt enable
   logic one_pulse_select; // One pulse mode
   logic pwm_select; // Pwm mode

   // Counter state
   logic [15:0] next_count; // Next counter value
   logic [2:0] prescale; // Cpu clock divider
   logic [2:0] pre_mask; // Selected divider mask
   logic tick; // Counter advance this cycle
   logic overflow_flag; // Sticky rollover flag
   logic ovf_clear_armed; // Status read saw overflow set

   // Byte buffers for the two counter views
   logic [7:0] cnt_low_buf; // Main view low byte buffer
   logic cnt_buf_valid; // Main view sequence open
   logic [7:0] alt_low_buf; // Alternate view low byte buffer
   logic alt_buf_valid; // Alternate view sequence open

   // Pin synchronisers, three bits side by side
   logic [2:0] sync_a; // First stage, read only by sync_b
   logic [2:0] sync_b; // Second stage, safe to use
   logic ext_prev; // Last external level
   logic ext_tick; // Selected external edge

   // Decoded bus strobes
   logic wr_ctrl_one;
   logic wr_ctrl_two;
   logic rd_status;
   logic acc_cnt_lo;
   logic acc_alt_lo;
   logic rd_cnt_hi;
   logic rd_cnt_lo;
   logic rd_alt_hi;
   logic rd_alt_lo;
   logic rd_cap1_hi;
   logic acc_cap1_lo;
   logic rd_cap2_hi;
   logic acc_cap2_lo;
   logic [7:0] next_rdata; // Read data before the register
   logic [7:0] status_byte; // Assembled status

   // Channel links
   frtc_chan_if cap_one ();
   frtc_chan_if cap_two ();

   // Field extraction
   assign clock_select_field = timer_control_two[FRTC_C2_CLK_LO +: 2];
   assign ext_clock_edge_select = timer_control_two[FRTC_C2_EXT_EDGE];
   assign one_pulse_select = timer_control_two[FRTC_C2_ONE_PULSE];
   assign pwm_select = timer_control_two[FRTC_C2_PWM];
   assign overflow_irq_enable = timer_control_one[FRTC_C1_OVF_IE];
   assign capture_irq_enable = timer_control_one[FRTC_C1_CAP_IE];
   assign one_pulse_active = one_pulse_select | pwm_select;

   // Address decode, each strobe a single cycle
   assign wr_ctrl_one = reg_wr && (reg_addr == FRTC_OFS_CTRL_ONE);
   assign wr_ctrl_two = reg_wr && (reg_addr == FRTC_OFS_CTRL_TWO);
   assign rd_status = reg_rd && (reg_addr == FRTC_OFS_STATUS);
   assign rd_cnt_hi = reg_rd && (reg_addr == FRTC_OFS_CNT_HI);
   assign rd_cnt_lo = reg_rd && (reg_addr == FRTC_OFS_CNT_LO);
   assign rd_alt_hi = reg_rd && (reg_addr == FRTC_OFS_ALT_HI);
   assign rd_alt_lo = reg_rd && (reg_addr == FRTC_OFS_ALT_LO);
   // Low byte access means read or write
   assign acc_cnt_lo = (reg_rd || reg_wr) && (reg_addr == FRTC_OFS_CNT_LO);
   assign acc_alt_lo = (reg_rd || reg_wr) && (reg_addr == FRTC_OFS_ALT_LO);
   assign rd_cap1_hi = reg_rd && (reg_addr == FRTC_OFS_CAP1_HI);
   assign acc_cap1_lo = (reg_rd || reg_wr) && (reg_addr == FRTC_OFS_CAP1_LO);
   assign rd_cap2_hi = reg_rd && (reg_addr == FRTC_OFS_CAP2_HI);
   assign acc_cap2_lo = (reg_rd || reg_wr) && (reg_addr == FRTC_OFS_CAP2_LO);

   // Control one, reserved bits kept at zero
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) timer_control_one <= FRTC_RESET_BYTE;
      else if (wr_ctrl_one) timer_control_one <= reg_wdata & FRTC_C1_MASK;
   end

   // Control two, reserved bits kept at zero
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) timer_control_two <= FRTC_RESET_BYTE;
      else if (wr_ctrl_two) timer_control_two <= reg_wdata & FRTC_C2_MASK;
   end

   // Two-flop synchronisers for every pin input
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sync_a <= 3'h0;
         sync_b <= 3'h0;
      end else begin
         sync_a <= {ext_clock_pin, capture_pin_two, capture_pin_one};
         sync_b <= sync_a;
      end
   end

   // External edge detector on the synchronised level
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) ext_prev <= 1'b0;
      else ext_prev <= sync_b[2];
   end

   // Sampling limits the pin to well under a quarter of clk
   assign ext_tick = ext_clock_edge_select ? (sync_b[2] & ~ext_prev)
                                           : (~sync_b[2] & ext_prev);

   // Divider mask per select code
   always_comb begin
      pre_mask = FRTC_PRE_DIV4;
      case (clock_select_field)
         FRTC_CLK_DIV4: pre_mask = FRTC_PRE_DIV4;
         FRTC_CLK_DIV8: pre_mask = FRTC_PRE_DIV8;
         FRTC_CLK_DIV2: pre_mask = FRTC_PRE_DIV2;
         default: pre_mask = FRTC_PRE_DIV4;
      endcase
   end

   // Free prescaler, frozen with the counter in halt
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) prescale <= 3'h0;
      else if (!halt_mode) prescale <= prescale + 3'h1;
   end

   // Tick source: divided cpu clock or external edge
   always_comb begin
      if (halt_mode) tick = 1'b0;
      else if (clock_select_field == FRTC_CLK_EXT) tick = ext_tick;
      else tick = ((prescale & pre_mask) == pre_mask);
   end

   // Next counter value, reload has priority over counting
   always_comb begin
      next_count = counter_value;
      if ((reg_wr && (reg_addr == FRTC_OFS_CNT_LO)) ||
          (reg_wr && (reg_addr == FRTC_OFS_ALT_LO))) begin
         next_count = FRTC_CNT_RELOAD;
      end else if (tick) begin
         next_count = counter_value + 16'h0001;
      end
   end

   // Counter register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) counter_value <= FRTC_CNT_RELOAD;
      else counter_value <= next_count;
   end

   // Overflow clear step one, only the main low byte ends it
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) ovf_clear_armed <= 1'b0;
      else if (acc_cnt_lo) ovf_clear_armed <= 1'b0;
      else if (rd_status && overflow_flag) ovf_clear_armed <= 1'b1;
   end

   // Overflow flag, a rollover beats a clear in the same cycle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         overflow_flag <= 1'b0;
      end else if (tick && (counter_value == FRTC_CNT_MAX)) begin
         overflow_flag <= 1'b1;
      end else if (acc_cnt_lo && ovf_clear_armed) begin
         overflow_flag <= 1'b0;
      end
   end

   // Main view buffer, repeated high reads keep the first snapshot
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_low_buf <= 8'h00;
         cnt_buf_valid <= 1'b0;
      end else if (rd_cnt_hi && !cnt_buf_valid) begin
         cnt_low_buf <= counter_value[7:0];
         cnt_buf_valid <= 1'b1;
      end else if (rd_cnt_lo) begin
         cnt_buf_valid <= 1'b0;
      end
   end

   // Alternate view buffer, same behaviour
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         alt_low_buf <= 8'h00;
         alt_buf_valid <= 1'b0;
      end else if (rd_alt_hi && !alt_buf_valid) begin
         alt_low_buf <= counter_value[7:0];
         alt_buf_valid <= 1'b1;
      end else if (rd_alt_lo) begin
         alt_buf_valid <= 1'b0;
      end
   end

   // Capture channel one, given up to the pulse modes
   assign cap_one.pin_level = sync_b[0];
   assign cap_one.edge_rise = timer_control_one[FRTC_C1_EDGE1];
   assign cap_one.enable = ~one_pulse_active;
   assign cap_one.count = counter_value;
   assign cap_one.status_read = rd_status;
   assign cap_one.high_read = rd_cap1_hi;
   assign cap_one.low_access = acc_cap1_lo;

   // Capture channel two, absent in the reduced variant
   assign cap_two.pin_level = sync_b[1];
   assign cap_two.edge_rise = timer_control_two[FRTC_C2_EDGE2];
   assign cap_two.enable = ~REDUCED;
   assign cap_two.count = counter_value;
   assign cap_two.status_read = rd_status;
   assign cap_two.high_read = rd_cap2_hi;
   assign cap_two.low_access = acc_cap2_lo;

   frtc_capture_chan u_cap_one (
      .clk(clk),
      .rst_n(rst_n),
      .ch(cap_one)
   );

   frtc_capture_chan u_cap_two (
      .clk(clk),
      .rst_n(rst_n),
      .ch(cap_two)
   );

   // Status byte, unused bits read zero
   always_comb begin
      status_byte = 8'h00;
      status_byte[FRTC_ST_CAP1] = cap_one.flag;
      status_byte[FRTC_ST_CAP2] = cap_two.flag & ~REDUCED;
      status_byte[FRTC_ST_OVF] = overflow_flag;
   end

   // Read mux, unmapped addresses return zero
   always_comb begin
      next_rdata = 8'h00;
      case (reg_addr)
         FRTC_OFS_CTRL_ONE: next_rdata = timer_control_one;
         FRTC_OFS_CTRL_TWO: next_rdata = timer_control_two;
         FRTC_OFS_STATUS: next_rdata = status_byte;
         FRTC_OFS_CAP1_HI: next_rdata = cap_one.value[15:8];
         FRTC_OFS_CAP1_LO: next_rdata = cap_one.value[7:0];
         // Second capture reads zero when the channel is absent
         FRTC_OFS_CAP2_HI: next_rdata = REDUCED ? 8'h00 : cap_two.value[15:8];
         FRTC_OFS_CAP2_LO: next_rdata = REDUCED ? 8'h00 : cap_two.value[7:0];
         FRTC_OFS_CNT_HI: next_rdata = counter_value[15:8];
         // Buffered low byte during a sequence, live afterwards
         FRTC_OFS_CNT_LO: next_rdata = cnt_buf_valid ? cnt_low_buf : counter_value[7:0];
         FRTC_OFS_ALT_HI: next_rdata = counter_value[15:8];
         FRTC_OFS_ALT_LO: next_rdata = alt_buf_valid ? alt_low_buf : counter_value[7:0];
         default: next_rdata = 8'h00;
      endcase
   end

   // Read data stand one cycle after the strobe, zero otherwise
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) reg_rdata <= 8'h00;
      else if (reg_rd) reg_rdata <= next_rdata;
      else reg_rdata <= 8'h00;
   end

   // Requests stay pending in the flags while masked or disabled
   assign timer_irq = ~cpu_irq_mask &
                      ((overflow_flag & overflow_irq_enable) |
                       ((cap_one.flag | (cap_two.flag & ~REDUCED)) & capture_irq_enable));
endmodule : frtc_top

// ===== testbench.sv
`timescale 1ns/10ps
// Self-checking bench for the free-running timer
module testbench;
   import frtc_pkg::*;
   logic clk, rst_n, reg_wr, reg_rd, cpu_irq_mask, halt_mode, ext_go;
   logic ext_clock_pin, capture_pin_one, capture_pin_two, timer_irq, one_pulse_active;
   logic [3:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, rv;
   logic [15:0] counter_value;
   logic [1:0] cap_go;
   int num_errors, n_compared, n;
   frtc_top DUT (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cpu_irq_mask(cpu_irq_mask),
      .halt_mode(halt_mode), .ext_clock_pin(ext_clock_pin), .capture_pin_one(capture_pin_one),
      .capture_pin_two(capture_pin_two), .timer_irq(timer_irq), .counter_value(counter_value),
      .one_pulse_active(one_pulse_active));
   frtc_pins PINS (.clk(clk), .rst_n(rst_n), .ext_go(ext_go), .cap_go(cap_go),
      .ext_clock_pin(ext_clock_pin), .capture_pin_one(capture_pin_one),
      .capture_pin_two(capture_pin_two));
   always #50 clk = ~clk;
   // Compare and tally
   task automatic chk(input string what, input logic [15:0] e, input logic [15:0] got);
      n_compared++;
      if (got !== e) begin
         $display("MISMATCH %s expected %h seen %h", what, e, got);
         num_errors++;
      end
   endtask : chk
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
      #1;
   endtask : wr
   // Data stands only in the cycle after the strobe
   task automatic rd(input logic [3:0] a);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #10;
      rv = reg_rdata;
   endtask : rd
   task automatic rdc(input string what, input logic [3:0] a, input logic [7:0] e);
      rd(a);
      chk(what, {8'h00, e}, {8'h00, rv});
   endtask : rdc
   // Whole pulses only; partner needs the gap
   task automatic ext_pulse(input int k);
      repeat (k) begin
         @(posedge clk);
         ext_go <= 1'b1;
         @(posedge clk);
         ext_go <= 1'b0;
         repeat (12) @(posedge clk);
      end
   endtask : ext_pulse
   // Capture latency is three cycles, six is ample
   task automatic cap_toggle(input logic [1:0] m);
      @(posedge clk);
      cap_go <= m;
      @(posedge clk);
      cap_go <= 2'b00;
      repeat (6) @(posedge clk);
   endtask : cap_toggle
   // Bounded wait for the next counter change
   task automatic wait_change;
      logic [15:0] last;
      last = counter_value;
      n = 0;
      do begin
         @(posedge clk);
         #1;
         n++;
      end while (counter_value === last && n < 40);
   endtask : wait_change
   // Reset values, counter held by halt
   task automatic t_reset;
      chk("cnt_reset", FRTC_CNT_RELOAD, counter_value);
      rdc("ctrl_one", FRTC_OFS_CTRL_ONE, 8'h00);
      rdc("status", FRTC_OFS_STATUS, 8'h00);
      rdc("cnt_hi", FRTC_OFS_CNT_HI, 8'hff);
      rdc("cnt_lo", FRTC_OFS_CNT_LO, 8'hfc);
      rdc("alt_lo", FRTC_OFS_ALT_LO, 8'hfc);
      rdc("unmapped", 4'hf, 8'h00);
   endtask : t_reset
   // Tick period for each internal select code
   task automatic t_div;
      logic [1:0] codes [3] = '{FRTC_CLK_DIV4, FRTC_CLK_DIV8, FRTC_CLK_DIV2};
      int per [3] = '{4, 8, 2};
      @(posedge clk);
      halt_mode <= 1'b0;
      for (int i = 0; i < 3; i++) begin
         wr(FRTC_OFS_CTRL_TWO, {6'h00, codes[i]});
         wait_change();
         wait_change();
         chk("tick_period", 16'(per[i]), 16'(n));
      end
   endtask : t_div
   // External clock, reload from both views, frozen low byte
   task automatic t_ext_seq;
      wr(FRTC_OFS_CTRL_TWO, 8'h07);
      wr(FRTC_OFS_CNT_LO, 8'h55);
      chk("reload", FRTC_CNT_RELOAD, counter_value);
      ext_pulse(2);
      chk("ext_count", 16'hfffe, counter_value);
      wr(FRTC_OFS_ALT_LO, 8'h00);
      chk("alt_reload", FRTC_CNT_RELOAD, counter_value);
      rdc("hi_first", FRTC_OFS_CNT_HI, 8'hff);
      ext_pulse(1);
      rdc("hi_again", FRTC_OFS_CNT_HI, 8'hff);
      rdc("lo_frozen", FRTC_OFS_CNT_LO, 8'hfc);
      rdc("lo_live", FRTC_OFS_CNT_LO, 8'hfd);
   endtask : t_ext_seq
   // Rollover flag, masking and the two-step clear
   task automatic t_ovf;
      wr(FRTC_OFS_CTRL_ONE, 8'h20);
      ext_pulse(3);
      chk("wrap", 16'h0000, counter_value);
      chk("irq_ovf", 16'h1, {15'h0, timer_irq});
      @(posedge clk);
      cpu_irq_mask <= 1'b1;
      #1;
      chk("irq_masked", 16'h0, {15'h0, timer_irq});
      @(posedge clk);
      cpu_irq_mask <= 1'b0;
      rd(FRTC_OFS_CNT_LO);
      rdc("ovf_kept", FRTC_OFS_STATUS, 8'h20);
      chk("irq_pend", 16'h1, {15'h0, timer_irq});
      rd(FRTC_OFS_ALT_LO);
      rdc("ovf_alt", FRTC_OFS_STATUS, 8'h20);
      rd(FRTC_OFS_CNT_LO);
      rdc("ovf_clr", FRTC_OFS_STATUS, 8'h00);
   endtask : t_ovf
   // Edge select on both channels; blocking, clearing and overwrite on channel one
   task automatic t_cap;
      wr(FRTC_OFS_CTRL_ONE, 8'h81);
      cap_toggle(2'b01);
      chk("irq_cap", 16'h1, {15'h0, timer_irq});
      rdc("st_cap1", FRTC_OFS_STATUS, 8'h80);
      rdc("cap1_hi", FRTC_OFS_CAP1_HI, 8'h00);
      ext_pulse(1);
      cap_toggle(2'b01);
      cap_toggle(2'b01);
      rdc("cap1_blk", FRTC_OFS_CAP1_LO, 8'h00);
      rdc("st_clr", FRTC_OFS_STATUS, 8'h00);
      cap_toggle(2'b01);
      rdc("st_fall", FRTC_OFS_STATUS, 8'h00);
      cap_toggle(2'b01);
      rdc("cap1_new_hi", FRTC_OFS_CAP1_HI, 8'h00);
      rdc("cap1_new_lo", FRTC_OFS_CAP1_LO, 8'h01);
      cap_toggle(2'b10);
      rdc("st_rise2", FRTC_OFS_STATUS, 8'h80);
      cap_toggle(2'b10);
      rdc("st_fall2", FRTC_OFS_STATUS, 8'hc0);
      rdc("cap2_lo", FRTC_OFS_CAP2_LO, 8'h01);
   endtask : t_cap
   // Pulse mode keeps channel two capturing
   task automatic t_opm;
      rd(FRTC_OFS_STATUS);
      rd(FRTC_OFS_CAP1_LO);
      rd(FRTC_OFS_CAP2_LO);
      wr(FRTC_OFS_CTRL_TWO, 8'h17);
      chk("opm", 16'h1, {15'h0, one_pulse_active});
      cap_toggle(2'b11);
      cap_toggle(2'b11);
      rdc("st_opm", FRTC_OFS_STATUS, 8'h40);
   endtask : t_opm
   // Verdict and end of run
   task automatic test_done;
      $display("Compared %0d, mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : test_done
   initial begin
      clk = 1'b0;
      rst_n = 1'b0;
      {reg_wr, reg_rd, ext_go, cpu_irq_mask} = 4'h0;
      halt_mode = 1'b1;
      reg_addr = 4'h0;
      reg_wdata = 8'h00;
      cap_go = 2'b00;
      num_errors = 0;
      n_compared = 0;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_div();
      t_ext_seq();
      t_ovf();
      t_cap();
      t_opm();
      test_done();
   end
   // Watchdog well beyond the expected run length
   initial begin
      repeat (5000) @(posedge clk);
      num_errors++;
      test_done();
   end
endmodule : testbench
